// *** ispm_pkg.sv ***
// shared constants, types and helpers for the input sync parameter monitor
package ispm_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int WORD_LSB = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_ENTRY_COUNT = 6'h00;
    localparam logic [5:0] IDX_MODE = 6'h01;
    localparam logic [5:0] IDX_CYCLE = 6'h02;
    localparam logic [5:0] IDX_SHIFT = 6'h03;
    localparam logic [5:0] IDX_SUPPORTED = 6'h04;
    localparam logic [5:0] IDX_MIN_CYCLE = 6'h05;
    localparam logic [5:0] IDX_LATENCY = 6'h06;
    localparam logic [5:0] IDX_MIN_DELAY = 6'h07;
    localparam logic [5:0] IDX_CMD = 6'h08;
    localparam logic [5:0] IDX_MAX_DELAY = 6'h09;
    localparam logic [5:0] IDX_MISSED = 6'h0B;
    localparam logic [5:0] IDX_OVERRUN = 6'h0C;
    localparam logic [5:0] IDX_SHORT = 6'h0D;
    localparam logic [5:0] IDX_FAULT = 6'h20;

    ////////////////////////////////////////////////////////////////////////////
    // reset and constant values
    localparam logic [7:0] RST_ENTRY_COUNT = 8'h20;
    localparam logic [15:0] RST_MODE = 16'h0000;
    localparam logic [31:0] RST_CYCLE = 32'h000F4240;
    localparam logic [31:0] RST_SHIFT = 32'h00000384;
    localparam logic [15:0] RST_SUPPORTED = 16'h8001;
    localparam logic [31:0] RST_MIN_CYCLE = 32'h00002710;
    localparam logic [31:0] RST_LATENCY = 32'h00000000;
    localparam logic [31:0] RST_MIN_DELAY = 32'h00000384;
    localparam logic [15:0] RST_CMD = 16'h0000;
    localparam logic [31:0] RST_MAX_DELAY = 32'h00000384;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic RST_FAULT = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // sync mode codes and commands
    localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
    localparam logic [15:0] MODE_SM3 = 16'h0001;
    localparam logic [15:0] MODE_SYNC0 = 16'h0002;
    localparam logic [15:0] MODE_SYNC1 = 16'h0003;
    localparam logic [15:0] MODE_SM2 = 16'h0022;
    localparam logic [15:0] CMD_STOP = 16'h0000;
    localparam logic [15:0] CMD_START = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // supported-modes input shift field
    localparam int SUP_SHIFT_LSB = 4;
    localparam int SUP_SHIFT_MSB = 5;
    localparam logic [1:0] SHIFT_LOCAL = 2'h1;
    localparam logic [1:0] SHIFT_SYNC1 = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ = 250;
    localparam logic [31:0] CLK_PERIOD_NS = 32'(1000 / CLK_MHZ);
    localparam logic [31:0] NS_LIMIT = 32'hFFFFFFFF - CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake states
    typedef enum logic [1:0] {
        ISPM_BUS_IDLE = 2'h1,
        ISPM_BUS_ACK = 2'h2
    } ispm_bus_state_type;

    function automatic logic [31:0] ispm_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : ispm_merge

    function automatic logic [31:0] ispm_ns_step(input logic [31:0] v);
        return (v > NS_LIMIT) ? 32'hFFFFFFFF : v + CLK_PERIOD_NS;
    endfunction : ispm_ns_step
endpackage : ispm_pkg

// *** ispm_sat_counter.sv ***
// saturating event counter
`timescale 1ns/100ps
module ispm_sat_counter #(
    parameter int WIDTH = ispm_pkg::CNT_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_inc,
    output logic [WIDTH-1:0] o_count
);
    import ispm_pkg::*;

    wire logic at_max = &o_count;
    wire logic [WIDTH-1:0] next_count = (i_inc && !at_max) ? o_count + 1'b1 : o_count;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= '0;
        end else begin
            o_count <= next_count;
        end
    end

    AST_CNT_SATURATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (at_max && i_inc) |=> at_max) else $error("counter wrapped");
    AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!at_max && i_inc) |=> (o_count == $past(o_count) + 1'b1))
        else $error("counter did not step by one");
endmodule : ispm_sat_counter

// *** ispm_top.sv ***
// input sync parameter monitor: register bank, timing measurement, error counters
//
// Overview of operation
// - sync mode is 16 bits, resets to free run 0, and codes 1, 2, 3 and 34 pick the sync source.
// - cycle period in ns resets to one million and times the local timer in free run.
// - shift time reports ns from SYNC0 to input sampling, read only, resetting to 900.
// - supported-modes word is read only with reset 0x8001 and its mode flag bits.
// - supported-modes bits 4-5 read 01 for local-event shift with outputs, 10 for SYNC1 shift.
// - minimum cycle period reads ten thousand ns and the master must not set less.
// - calc-and-copy time reports ns from sampling to availability, read only, reset zero.
// - writing 1 to the command entry starts measurement and writing 0 stops it.
// - while measuring in sync-event mode, shift, calc-and-copy and max delay entries keep the largest values seen.
// - starting a measurement first clears the previous maxima.
// - max delay reports ns from SYNC1 to input sampling, resetting to 900.
// - in sync-event mode, each missed manager event while operational is counted in 16 bits.
// - while operational, each late-finishing or too-early cycle is counted in 16 bits.
// - in sync-event mode, each too-short SYNC0 to SYNC1 spacing is counted in 16 bits.
// - in sync-event mode a read-only fault flag shows the last cycle's outputs were late.
// - the first entry reads the highest subindex, thirty-two.
`timescale 1ns/100ps
module ispm_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ispm_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [ispm_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [ispm_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_sync0,
    input wire logic i_sync1,
    input wire logic i_sm_event,
    input wire logic i_input_sample,
    input wire logic i_input_ready,
    input wire logic i_output_late,
    input wire logic i_operational,
    input wire logic i_outputs_present,
    input wire logic i_shift_capable,
    output logic o_cycle_start,
    output logic o_measure_active,
    output logic o_dc_mode
);
    import ispm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    ispm_bus_state_type bus_state;
    logic [15:0] sync_mode;
    logic [31:0] cycle_period;
    logic [15:0] measure_cmd;
    logic [31:0] shift_max;
    logic [31:0] calc_max;
    logic [31:0] delay_max;
    logic [31:0] ns_since_sync0;
    logic [31:0] ns_since_sync1;
    logic [31:0] ns_since_sample;
    logic [31:0] local_ns;
    logic sm_seen;
    logic cycle_armed;
    logic cycle_busy;
    logic sample_pending;
    logic sample_open;
    logic late_seen;
    logic sync_fault;
    logic [15:0] missed_count;
    logic [15:0] overrun_count;
    logic [15:0] short_count;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic [5:0] word_idx = i_avs_address[ADDR_W-1:WORD_LSB];
    wire logic bus_req = i_avs_read | i_avs_write;
    wire logic in_ack = (bus_state == ISPM_BUS_ACK);
    wire logic wr_fire = i_avs_write && in_ack;
    wire logic wr_mode = wr_fire && (word_idx == IDX_MODE);
    wire logic wr_cycle = wr_fire && (word_idx == IDX_CYCLE);
    wire logic wr_cmd = wr_fire && (word_idx == IDX_CMD);
    wire logic [31:0] mode_merged = ispm_merge({16'h0000, sync_mode}, i_avs_writedata,
        i_avs_byteenable);
    wire logic [31:0] cycle_merged = ispm_merge(cycle_period, i_avs_writedata,
        i_avs_byteenable);
    wire logic [31:0] cmd_merged = ispm_merge({16'h0000, measure_cmd}, i_avs_writedata,
        i_avs_byteenable);
    wire logic start_wr = wr_cmd && (cmd_merged[15:0] == CMD_START);
    wire logic measuring = (measure_cmd == CMD_START);

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    wire logic free_run = (sync_mode == MODE_FREE_RUN);
    wire logic sm_mode = (sync_mode == MODE_SM3) || (sync_mode == MODE_SM2);
    wire logic dc_mode = (sync_mode == MODE_SYNC0) || (sync_mode == MODE_SYNC1);
    wire logic [31:0] local_step = ispm_ns_step(local_ns);
    wire logic local_tick = free_run && (local_step >= cycle_period);
    wire logic cycle_evt = free_run ? local_tick :
                           sm_mode ? i_sm_event :
                           (sync_mode == MODE_SYNC0) ? i_sync0 :
                           (sync_mode == MODE_SYNC1) ? i_sync1 : 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // event detection
    wire logic missed_evt = dc_mode && i_operational && i_sync0 && cycle_armed &&
        !sm_seen && !i_sm_event;
    wire logic overrun_evt = i_operational && cycle_evt && cycle_busy &&
        !i_input_ready;
    wire logic short_evt = dc_mode && i_sync1 && sample_pending &&
        !i_input_sample;
    // elapsed time up to and including this cycle
    wire logic [31:0] next_ns_since_sync0 = i_sync0 ? 32'h00000000 :
        ispm_ns_step(ns_since_sync0);
    wire logic [31:0] next_ns_since_sync1 = i_sync1 ? 32'h00000000 :
        ispm_ns_step(ns_since_sync1);
    wire logic [31:0] next_ns_since_sample = i_input_sample ? 32'h00000000 :
        ispm_ns_step(ns_since_sample);
    wire logic upd_shift = measuring && dc_mode && i_input_sample &&
        (next_ns_since_sync0 > shift_max);
    wire logic upd_delay = measuring && dc_mode && i_input_sample &&
        (next_ns_since_sync1 > delay_max);
    wire logic upd_calc = measuring && dc_mode && i_input_ready && sample_open &&
        (next_ns_since_sample > calc_max);

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    wire logic [15:0] supported_word = {RST_SUPPORTED[15:SUP_SHIFT_MSB+1],
        (i_shift_capable ? (i_outputs_present ? SHIFT_LOCAL : SHIFT_SYNC1) :
        RST_SUPPORTED[SUP_SHIFT_MSB:SUP_SHIFT_LSB]),
        RST_SUPPORTED[SUP_SHIFT_LSB-1:0]};
    wire logic [31:0] rd_data =
        (word_idx == IDX_ENTRY_COUNT) ? {24'h000000, RST_ENTRY_COUNT} :
        (word_idx == IDX_MODE) ? {16'h0000, sync_mode} :
        (word_idx == IDX_CYCLE) ? cycle_period :
        (word_idx == IDX_SHIFT) ? shift_max :
        (word_idx == IDX_SUPPORTED) ? {16'h0000, supported_word} :
        (word_idx == IDX_MIN_CYCLE) ? RST_MIN_CYCLE :
        (word_idx == IDX_LATENCY) ? calc_max :
        (word_idx == IDX_MIN_DELAY) ? RST_MIN_DELAY :
        (word_idx == IDX_CMD) ? {16'h0000, measure_cmd} :
        (word_idx == IDX_MAX_DELAY) ? delay_max :
        (word_idx == IDX_MISSED) ? {16'h0000, missed_count} :
        (word_idx == IDX_OVERRUN) ? {16'h0000, overrun_count} :
        (word_idx == IDX_SHORT) ? {16'h0000, short_count} :
        (word_idx == IDX_FAULT) ? {31'h00000000, sync_fault} : 32'h00000000;
    wire ispm_bus_state_type next_bus_state = (!in_ack && bus_req) ? ISPM_BUS_ACK :
        ISPM_BUS_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave, one wait state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_state <= ISPM_BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            o_avs_waitrequest <= (next_bus_state != ISPM_BUS_ACK);
            o_avs_readdata <= (next_bus_state == ISPM_BUS_ACK) ? rd_data : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable entries
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_mode <= RST_MODE;
            cycle_period <= RST_CYCLE;
            measure_cmd <= RST_CMD;
        end else begin
            sync_mode <= wr_mode ? mode_merged[15:0] : sync_mode;
            cycle_period <= wr_cycle ? cycle_merged : cycle_period;
            measure_cmd <= wr_cmd ? cmd_merged[15:0] : measure_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // elapsed-time counters and local timer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ns_since_sync0 <= 32'h00000000;
            ns_since_sync1 <= 32'h00000000;
            ns_since_sample <= 32'h00000000;
            local_ns <= 32'h00000000;
        end else begin
            ns_since_sync0 <= next_ns_since_sync0;
            ns_since_sync1 <= next_ns_since_sync1;
            ns_since_sample <= next_ns_since_sample;
            local_ns <= (!free_run || local_tick) ? 32'h00000000 : local_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measured maxima
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_max <= RST_SHIFT;
            calc_max <= RST_LATENCY;
            delay_max <= RST_MAX_DELAY;
        end else if (start_wr) begin
            shift_max <= 32'h00000000;
            calc_max <= 32'h00000000;
            delay_max <= 32'h00000000;
        end else begin
            shift_max <= upd_shift ? next_ns_since_sync0 : shift_max;
            calc_max <= upd_calc ? next_ns_since_sample : calc_max;
            delay_max <= upd_delay ? next_ns_since_sync1 : delay_max;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle tracking flags, set wins over clear except cycle_armed, which leaving sync mode or operational clears
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sm_seen <= 1'b0;
            cycle_armed <= 1'b0;
            cycle_busy <= 1'b0;
            sample_pending <= 1'b0;
            sample_open <= 1'b0;
            late_seen <= 1'b0;
        end else begin
            sm_seen <= i_sm_event || (sm_seen && !i_sync0);
            cycle_armed <= dc_mode && i_operational && (cycle_armed || i_sync0);
            cycle_busy <= cycle_evt || (cycle_busy && !i_input_ready);
            sample_pending <= i_sync0 || (sample_pending && !i_input_sample);
            sample_open <= i_input_sample || (sample_open && !i_input_ready);
            late_seen <= i_output_late || (late_seen && !i_sync0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault flag and outputs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_fault <= RST_FAULT;
            o_cycle_start <= 1'b0;
            o_measure_active <= 1'b0;
            o_dc_mode <= 1'b0;
        end else begin
            sync_fault <= !dc_mode ? 1'b0 :
                i_sync0 ? (late_seen || i_output_late) : sync_fault;
            o_cycle_start <= cycle_evt;
            o_measure_active <= measuring;
            o_dc_mode <= dc_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error counters
    ispm_sat_counter #(.WIDTH(CNT_W)) u_missed (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_inc(missed_evt),
        .o_count(missed_count)
    );
    ispm_sat_counter #(.WIDTH(CNT_W)) u_overrun (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_inc(overrun_evt),
        .o_count(overrun_count)
    );
    ispm_sat_counter #(.WIDTH(CNT_W)) u_short (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_inc(short_evt),
        .o_count(short_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_MODE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_mode && i_avs_byteenable == 4'hF) |=> (sync_mode == $past(i_avs_writedata[15:0])))
        else $error("sync mode write lost");
    AST_LOCAL_TICK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (free_run && local_tick && !wr_mode && !wr_cycle) |=> (local_ns == 32'h00000000))
        else $error("local timer not restarted");
    AST_ENTRY_COUNT_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (in_ack && i_avs_read && word_idx == IDX_ENTRY_COUNT) |->
        (o_avs_readdata == 32'h00000020 && !o_avs_waitrequest))
        else $error("entry count read wrong");
    AST_MIN_CYCLE_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (in_ack && i_avs_read && word_idx == IDX_MIN_CYCLE) |->
        (o_avs_readdata == 32'h00002710)) else $error("minimum cycle read wrong");
    AST_START_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        start_wr |=> (shift_max == 32'h00000000 && calc_max == 32'h00000000 &&
        delay_max == 32'h00000000 && measuring)) else $error("maxima not cleared on start");
    AST_STOP_CMD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_cmd && i_avs_byteenable == 4'hF && i_avs_writedata == 32'h00000000) |=>
        (!measuring ##1 !o_measure_active)) else $error("stop not honoured");
    AST_SHIFT_MAX: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (upd_shift && !start_wr) |=> (shift_max == $past(next_ns_since_sync0)))
        else $error("shift maximum not kept");
    AST_HOLD_STOPPED: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!measuring && !start_wr) |=> $stable(shift_max) && $stable(delay_max))
        else $error("maximum changed while stopped");
    AST_OVERRUN_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (overrun_evt && overrun_count != 16'hFFFF) |=>
        (overrun_count == $past(overrun_count) + 16'h0001)) else $error("overrun not counted");
    AST_FAULT_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (dc_mode && i_sync0 && i_output_late && !wr_mode) |=> sync_fault)
        else $error("sync fault not raised");
    AST_MISSED_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!dc_mode) |=> $stable(missed_count)) else $error("missed count outside sync mode");
endmodule : ispm_top

// *** ispm_avs_master.sv ***
// avalon-mm master model standing for the fieldbus master
`timescale 1ns/100ps
module ispm_avs_master (
    input wire logic i_clk,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    output logic [7:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable,
    output logic o_timeout
);
    initial begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'hF;
        o_timeout = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one transfer, held until waitrequest is seen low or 64 clocks pass, which sets o_timeout
    task automatic access(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        o_address <= {idx, 2'b00};
        o_write <= wr;
        o_read <= !wr;
        o_writedata <= wd;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin
            o_timeout <= 1'b1;
        end
        rd = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask : access
endmodule : ispm_avs_master

// *** input_sync_parameter_monitor_bench.sv ***
// self-checking bench for the input sync parameter monitor
`timescale 1ns/100ps
module input_sync_parameter_monitor_bench;
    import ispm_pkg::*;
    logic i_clk, i_rstn, rd_, wr_, wq, dc, ma, cs, op, outp, shcap, tmo;
    logic [7:0] adr;
    logic [3:0] be;
    logic [31:0] wdat, rdq, rdat, rng, d;
    logic [31:0] mdl [0:63];
    logic [5:0] ev;
    int fails, checked, a, b, c;
    int idxs [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 32, 63};
    int modes [5] = '{0, 1, 2, 3, 34};

    ispm_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd_),
        .i_avs_write(wr_), .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdq), .o_avs_waitrequest(wq), .i_sync0(ev[0]), .i_sync1(ev[1]),
        .i_sm_event(ev[2]), .i_input_sample(ev[3]), .i_input_ready(ev[4]),
        .i_output_late(ev[5]), .i_operational(op), .i_outputs_present(outp),
        .i_shift_capable(shcap), .o_cycle_start(cs), .o_measure_active(ma), .o_dc_mode(dc));
    ispm_avs_master i_mst (.i_clk(i_clk), .i_waitrequest(wq), .i_readdata(rdq),
        .o_address(adr), .o_read(rd_), .o_write(wr_), .o_writedata(wdat),
        .o_byteenable(be), .o_timeout(tmo));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %08h expected %08h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input int idx, input logic [31:0] wd);
        i_mst.access(w, 6'(idx), wd, rdat);
        @(posedge i_clk);
        if (tmo === 1'b1) begin
            fails++;
            end_sim();
        end
    endtask : acc
    task automatic rdchk(input int idx);
        acc(1'b0, idx, 32'h0);
        chk(rdat, mdl[idx]);
    endtask : rdchk
    task automatic wr(input int idx, input logic [31:0] v);
        acc(1'b1, idx, v);
        if (idx == 1 || idx == 8) mdl[idx] = {16'h0, v[15:0]};
        if (idx == 2) mdl[idx] = v;
    endtask : wr
    task automatic pulse(input logic [5:0] m, input int gap);
        ev <= m;
        @(posedge i_clk);
        ev <= 6'h00;
        repeat (gap) @(posedge i_clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rng = 32'h7C59A669;
        i_rstn = 1'b0;
        ev = 6'h00;
        op = 1'b0;
        outp = 1'b0;
        shcap = 1'b0;
        for (int i = 0; i < 64; i++) mdl[i] = 32'h0;
        mdl[0] = 32'h20;
        mdl[2] = 32'h000F4240;
        mdl[3] = 32'h384;
        mdl[4] = 32'h8001;
        mdl[5] = 32'h2710;
        mdl[7] = 32'h384;
        mdl[9] = 32'h384;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        foreach (idxs[i]) rdchk(idxs[i]);
        foreach (idxs[i]) if (!(idxs[i] inside {1, 2, 8})) wr(idxs[i], xs());
        foreach (idxs[i]) rdchk(idxs[i]);
        repeat (3) begin
            wr(2, 32'd10000 + xs() % 32'd1000000);
            rdchk(2);
        end
        wr(2, 32'h00002710);
        for (a = 0; a < 3000 && cs !== 1'b1; a++) @(posedge i_clk);
        @(posedge i_clk);
        for (b = 1; b < 3000 && cs !== 1'b1; b++) @(posedge i_clk);
        if (a == 3000 || b == 3000) begin
            fails++;
            end_sim();
        end
        chk(b, 10000 / 4);
        foreach (modes[i]) begin
            wr(1, 32'(modes[i]));
            rdchk(1);
            chk({31'h0, dc}, 32'(modes[i] == 2 || modes[i] == 3));
        end
        pulse(6'h04, 1);
        chk({31'h0, cs}, 32'h1);
        shcap <= 1'b1;
        outp <= 1'b1;
        mdl[4] = 32'h8011;
        rdchk(4);
        outp <= 1'b0;
        mdl[4] = 32'h8021;
        rdchk(4);
        wr(1, 32'h2);
        op <= 1'b1;
        wr(8, 32'h1);
        @(posedge i_clk);
        chk({31'h0, ma}, 32'h1);
        mdl[3] = 0;
        mdl[6] = 0;
        mdl[9] = 0;
        foreach (idxs[i]) if (idxs[i] inside {3, 6, 9}) rdchk(idxs[i]);
        a = 1 + xs() % 6;
        b = 1 + xs() % 6;
        c = 1 + xs() % 6;
        pulse(6'h10, 1);
        pulse(6'h01, a);
        pulse(6'h02, b);
        pulse(6'h08, c);
        pulse(6'h10, 1);
        pulse(6'h20, 1);
        pulse(6'h01, 2);
        mdl[3] = 4 * (a + b + 2);
        mdl[9] = 4 * (b + 1);
        mdl[6] = 4 * (c + 1);
        mdl[13] = 1;
        mdl[11] = 1;
        mdl[32] = 1;
        foreach (idxs[i]) rdchk(idxs[i]);
        pulse(6'h01, 2);
        mdl[11] = 2;
        mdl[12] = 1;
        mdl[32] = 0;
        foreach (idxs[i]) rdchk(idxs[i]);
        wr(8, 32'h0);
        @(posedge i_clk);
        chk({31'h0, ma}, 32'h0);
        pulse(6'h01, 7);
        pulse(6'h08, 2);
        mdl[11] = 3;
        mdl[12] = 2;
        foreach (idxs[i]) rdchk(idxs[i]);
        wr(8, 32'h1);
        mdl[3] = 0;
        mdl[6] = 0;
        mdl[9] = 0;
        foreach (idxs[i]) rdchk(idxs[i]);
        end_sim();
    end
endmodule : input_sync_parameter_monitor_bench
